// >>> tec_pkg.sv
// tec_pkg: register map, field positions, reset values, mode codes and decode
// assumes a 32-bit APB slave clocked by pclk at 40 MHz
package tec_pkg;

	// register byte offsets
	localparam logic [31:0] TEC_OFF_CTRL = 32'h0000_0000;
	localparam logic [31:0] TEC_OFF_CNT  = 32'h0000_0004;
	localparam logic [31:0] TEC_OFF_RA   = 32'h0000_0008;
	localparam logic [31:0] TEC_OFF_RB   = 32'h0000_000C;

	// control register field positions
	localparam int TEC_B_ENB  = 0;
	localparam int TEC_B_PNDB = 1;
	localparam int TEC_B_ENA  = 2;
	localparam int TEC_B_PNDA = 3;
	localparam int TEC_B_RUN  = 4;
	localparam int TEC_B_MODE = 5;

	// reset values
	localparam logic [7:0]  TEC_CTRL_RST = 8'h00;
	localparam logic [15:0] TEC_CNT_RST  = 16'h0000;
	localparam logic [15:0] TEC_RLD_RST  = 16'h0000;

	// instruction-cycle tick: one pclk in every TEC_TC_DIV
	localparam int          TEC_TC_W   = 4;
	localparam logic [3:0]  TEC_TC_DIV = 4'h4;
	localparam logic [3:0]  TEC_TC_LAST = TEC_TC_DIV - 4'h1;

	typedef enum logic [2:0] {
		TEC_M_PWM = 3'b001,
		TEC_M_EVT = 3'b010,
		TEC_M_CAP = 3'b100
	} tec_mode_t;

	// bits are {high, mid, low}
	function automatic tec_mode_t tec_decode(input logic [2:0] c);
		if (c[1])
			return TEC_M_CAP;
		else if (c[2])
			return TEC_M_PWM;
		else
			return TEC_M_EVT;
	endfunction

endpackage

// >>> tec_edge.sv
// tec_edge: two-flop synchroniser for one timer pin, with edge pulses
// assumes the pin is asynchronous to pclk
`timescale 1ns/1ps
module tec_edge (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// meta_q feeds sync_q only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign rise = sync_q & ~last_q;
	assign fall = ~sync_q & last_q;

endmodule // tec_edge

// >>> tec_timer.sv
// tec_timer: 16-bit down-counting timer with two reload/capture registers
// assumes an APB master on pclk; pin inputs are asynchronous
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps

//Behaviour
//- event counter mode decrements the timer on pin A edges, not on tc
//- in event counter mode the low mode bit picks rising or falling pin A edge
//- event counter underflow sets pending flag A; enable A raises the request
//- event counter mode: pin B rising edge sets pending flag B, gated by enable B
//- event counter mode never drives pin A
//- capture mode counts down every tc tick without stopping
//- capture mode copies the timer into register A or B on selected pin edges
//- capture edge polarity of pins A and B chosen by mode bits; falling A forces falling B
//- capture on pin A sets pending A, on pin B sets pending B, each gated
//- capture mode underflow sets the run bit, which requests via enable A
//- reading capture registers never disturbs the count
//- in PWM and event modes the run bit starts (1) and stops (0) the timer
//- enables gate the requests; pending flags latch regardless of enables
//- mode bits 101/100 PWM, 000/001 event, x1x capture; PWM counts on tc
//- capture edges: 010 A rise B rise, 110 A rise B fall, x11 both falling
module tec_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer_pin_a_in,
	output logic             timer_pin_a_out,
	output logic             timer_pin_a_oe,
	input  wire logic        timer_pin_b_in,
	output logic             irq_a,
	output logic             irq_b
);
	import tec_pkg::*;

	logic [2:0]          mode_bits_q;
	logic                run_or_underflow_bit_q;
	logic                pending_flag_a_q;
	logic                irq_enable_a_q;
	logic                pending_flag_b_q;
	logic                irq_enable_b_q;
	logic [15:0]         count_q;
	logic [15:0]         reload_capture_a_q;
	logic [15:0]         reload_capture_b_q;
	logic [TEC_TC_W-1:0] div_q;
	logic                tc_tick;
	logic                use_b_q;
	logic                pin_a_out_q;
	logic                pin_a_oe_q;
	logic                irq_a_q;
	logic                irq_b_q;
	logic [31:0]         prdata_q;
	logic                pready_q;
	logic                pslverr_q;
	tec_mode_t           mode;
	logic                a_rise;
	logic                a_fall;
	logic                b_rise;
	logic                b_fall;
	logic                setup;
	logic                wr;
	logic                wr_ctrl;
	logic                wr_cnt;
	logic                wr_ra;
	logic                wr_rb;
	logic                step;
	logic                uflow;
	logic                cap_a;
	logic                cap_b;
	logic                set_pnda;
	logic                set_pndb;
	logic                set_run;
	logic [7:0]          ctrl_rd;

	function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
		return a == off;
	endfunction

	tec_edge u_edge_a (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (timer_pin_a_in),
		.rise    (a_rise),
		.fall    (a_fall)
	);

	tec_edge u_edge_b (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (timer_pin_b_in),
		.rise    (b_rise),
		.fall    (b_fall)
	);

	assign mode = tec_decode(mode_bits_q);

	// apb decode; access completes in the cycle after setup
	assign setup   = psel & ~penable;
	assign wr      = psel & penable & pwrite & pready_q;
	assign wr_ctrl = wr & hit(paddr, TEC_OFF_CTRL);
	assign wr_cnt  = wr & hit(paddr, TEC_OFF_CNT);
	assign wr_ra   = wr & hit(paddr, TEC_OFF_RA);
	assign wr_rb   = wr & hit(paddr, TEC_OFF_RB);

	// instruction-cycle tick divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_q <= '0;
		else if (div_q == TEC_TC_LAST)
			div_q <= '0;
		else
			div_q <= div_q + 4'h1;
	end
	assign tc_tick = (div_q == TEC_TC_LAST);

	// count source per mode
	always_comb begin
		case (mode)
			TEC_M_PWM: step = tc_tick & run_or_underflow_bit_q;
			TEC_M_EVT: step = run_or_underflow_bit_q & (mode_bits_q[0] ? a_fall : a_rise);
			TEC_M_CAP: step = tc_tick;
			default:   step = 1'b0;
		endcase
	end
	assign uflow = step & (count_q == 16'h0000);

	// pin A edge from the low bit, pin B falls unless 010
	assign cap_a = (mode == TEC_M_CAP) & (mode_bits_q[0] ? a_fall : a_rise);
	assign cap_b = (mode == TEC_M_CAP)
		& ((mode_bits_q[2] | mode_bits_q[0]) ? b_fall : b_rise);

	assign set_pnda = ((mode == TEC_M_PWM) & uflow & ~use_b_q)
		| ((mode == TEC_M_EVT) & uflow)
		| cap_a;
	assign set_pndb = ((mode == TEC_M_PWM) & uflow & use_b_q)
		| ((mode == TEC_M_EVT) & b_rise)
		| cap_b;
	assign set_run = (mode == TEC_M_CAP) & uflow;

	// control bits; a hardware set beats a same-cycle software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_bits_q            <= TEC_CTRL_RST[TEC_B_MODE +: 3];
			run_or_underflow_bit_q <= TEC_CTRL_RST[TEC_B_RUN];
			pending_flag_a_q       <= TEC_CTRL_RST[TEC_B_PNDA];
			irq_enable_a_q         <= TEC_CTRL_RST[TEC_B_ENA];
			pending_flag_b_q       <= TEC_CTRL_RST[TEC_B_PNDB];
			irq_enable_b_q         <= TEC_CTRL_RST[TEC_B_ENB];
		end else begin
			if (wr_ctrl) begin
				mode_bits_q    <= pwdata[TEC_B_MODE +: 3];
				irq_enable_a_q <= pwdata[TEC_B_ENA];
				irq_enable_b_q <= pwdata[TEC_B_ENB];
			end
			run_or_underflow_bit_q <= (wr_ctrl ? pwdata[TEC_B_RUN] : run_or_underflow_bit_q)
				| set_run;
			pending_flag_a_q <= (wr_ctrl ? pwdata[TEC_B_PNDA] : pending_flag_a_q)
				| set_pnda;
			pending_flag_b_q <= (wr_ctrl ? pwdata[TEC_B_PNDB] : pending_flag_b_q)
				| set_pndb;
		end
	end

	// counter; a software write wins over the count step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			count_q <= TEC_CNT_RST;
		else if (wr_cnt)
			count_q <= pwdata[15:0];
		else if (uflow && mode == TEC_M_PWM)
			count_q <= use_b_q ? reload_capture_b_q : reload_capture_a_q;
		else if (step)
			count_q <= count_q - 16'h0001;
	end

	// pwm reload alternation, first underflow loads A
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			use_b_q <= 1'b0;
		else if (mode != TEC_M_PWM)
			use_b_q <= 1'b0;
		else if (uflow)
			use_b_q <= ~use_b_q;
	end

	// capture wins over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_capture_a_q <= TEC_RLD_RST;
			reload_capture_b_q <= TEC_RLD_RST;
		end else begin
			if (cap_a)
				reload_capture_a_q <= count_q;
			else if (wr_ra)
				reload_capture_a_q <= pwdata[15:0];
			if (cap_b)
				reload_capture_b_q <= count_q;
			else if (wr_rb)
				reload_capture_b_q <= pwdata[15:0];
		end
	end

	// pin A driven only in pwm; toggle on underflow in 101
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_a_out_q <= 1'b0;
			pin_a_oe_q  <= 1'b0;
		end else begin
			pin_a_oe_q <= (mode == TEC_M_PWM);
			if (mode == TEC_M_PWM && mode_bits_q[0] && uflow)
				pin_a_out_q <= ~pin_a_out_q;
		end
	end

	// requests follow the flags by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_a_q <= 1'b0;
			irq_b_q <= 1'b0;
		end else begin
			irq_a_q <= irq_enable_a_q & (pending_flag_a_q
				| ((mode == TEC_M_CAP) & run_or_underflow_bit_q));
			irq_b_q <= irq_enable_b_q & pending_flag_b_q;
		end
	end

	assign ctrl_rd = {mode_bits_q, run_or_underflow_bit_q, pending_flag_a_q,
		irq_enable_a_q, pending_flag_b_q, irq_enable_b_q};

	// read data captured at setup; reads have no side effects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			if (setup) begin
				if (hit(paddr, TEC_OFF_CTRL))
					prdata_q <= {24'h00_0000, ctrl_rd};
				else if (hit(paddr, TEC_OFF_CNT))
					prdata_q <= {16'h0000, count_q};
				else if (hit(paddr, TEC_OFF_RA))
					prdata_q <= {16'h0000, reload_capture_a_q};
				else if (hit(paddr, TEC_OFF_RB))
					prdata_q <= {16'h0000, reload_capture_b_q};
				else
					pslverr_q <= 1'b1;
			end
		end
	end

	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
	assign timer_pin_a_out = pin_a_out_q;
	assign timer_pin_a_oe  = pin_a_oe_q;
	assign irq_a           = irq_a_q;
	assign irq_b           = irq_b_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_evt_edge;
		mode == TEC_M_EVT && run_or_underflow_bit_q && !wr_cnt
			&& (mode_bits_q[0] ? a_fall : a_rise);
	endsequence

	property p_evt_count;
		s_evt_edge |=> count_q == $past(count_q) - 16'h0001;
	endproperty
	a_evt_count: assert property (p_evt_count) else $error("event edge missed");

	property p_evt_halt;
		mode == TEC_M_EVT && !run_or_underflow_bit_q && !wr_cnt |=> $stable(count_q);
	endproperty
	a_evt_halt: assert property (p_evt_halt) else $error("stopped timer moved");

	property p_evt_uf;
		s_evt_edge ##0 count_q == 16'h0000 |=> pending_flag_a_q && count_q == 16'hFFFF
			##1 irq_a == $past(irq_enable_a_q);
	endproperty
	a_evt_uf: assert property (p_evt_uf) else $error("event underflow lost");

	property p_evt_b;
		mode == TEC_M_EVT && b_rise |=> pending_flag_b_q;
	endproperty
	a_evt_b: assert property (p_evt_b) else $error("pin B edge lost");

	property p_evt_no_drive;
		mode == TEC_M_EVT ##1 mode == TEC_M_EVT |-> !timer_pin_a_oe;
	endproperty
	a_evt_no_drive: assert property (p_evt_no_drive) else $error("pin A driven");

	property p_cap_run;
		mode == TEC_M_CAP && tc_tick && !wr_cnt |=> count_q == $past(count_q) - 16'h0001;
	endproperty
	a_cap_run: assert property (p_cap_run) else $error("capture count stalled");

	property p_cap_a;
		cap_a |=> reload_capture_a_q == $past(count_q) && pending_flag_a_q;
	endproperty
	a_cap_a: assert property (p_cap_a) else $error("capture A wrong");

	property p_cap_b_fall;
		mode_bits_q == 3'b110 && b_fall |=> reload_capture_b_q == $past(count_q)
			&& pending_flag_b_q;
	endproperty
	a_cap_b_fall: assert property (p_cap_b_fall) else $error("capture B edge wrong");

	property p_cap_uf;
		mode == TEC_M_CAP && uflow |=> run_or_underflow_bit_q;
	endproperty
	a_cap_uf: assert property (p_cap_uf) else $error("underflow flag lost");

	property p_irq_b_gate;
		!irq_enable_b_q ##1 !irq_enable_b_q |-> !irq_b;
	endproperty
	a_irq_b_gate: assert property (p_irq_b_gate) else $error("request B not gated");

	property p_irq_a_gate;
		!irq_enable_a_q ##1 !irq_enable_a_q |-> !irq_a;
	endproperty
	a_irq_a_gate: assert property (p_irq_a_gate) else $error("request A not gated");

	// a pending flag latches even while its enable is off
	property p_flag_latch;
		set_pnda |=> pending_flag_a_q;
	endproperty
	a_flag_latch: assert property (p_flag_latch) else $error("pending A not latched");

	property p_cap_b_rise;
		mode_bits_q == 3'h2 && b_rise |=> reload_capture_b_q == $past(count_q)
			&& pending_flag_b_q;
	endproperty
	a_cap_b_rise: assert property (p_cap_b_rise) else $error("capture B rise wrong");

	sequence s_pwm_tick;
		mode == TEC_M_PWM && run_or_underflow_bit_q && tc_tick && !wr_cnt;
	endsequence

	property p_pwm_count;
		s_pwm_tick ##0 count_q != 16'h0000 |=> count_q == $past(count_q) - 16'h0001;
	endproperty
	a_pwm_count: assert property (p_pwm_count) else $error("pwm count not on tc");

	property p_pwm_toggle;
		mode_bits_q == 3'h5 && uflow |=> timer_pin_a_out != $past(timer_pin_a_out);
	endproperty
	a_pwm_toggle: assert property (p_pwm_toggle) else $error("pin A toggle lost");

endmodule // tec_timer

// >>> tec_pins.sv
// tec_pins: signal sources standing on the timer's two input pins
// assumes pclk from the bench; levels change only just after a rising edge
`timescale 1ns/1ps
module tec_pins (
	input  wire logic pclk,
	output logic      pin_a,
	output logic      pin_b
);
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
	end
	// each level is held five cycles so the synchroniser cannot miss it
	task automatic set_a(input logic v);
		@(posedge pclk);
		pin_a <= v;
		repeat (5) @(posedge pclk);
	endtask
	task automatic set_b(input logic v);
		@(posedge pclk);
		pin_b <= v;
		repeat (5) @(posedge pclk);
	endtask
endmodule // tec_pins

// >>> tec_timer_bench.sv
// tec_timer_bench: self-checking bench for tec_timer with an integer model
// assumes tec_pkg and tec_pins are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tec_timer_bench;
	import tec_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [31:0] paddr, pwdata, prdata, rd, ra, lf;
	logic        pa_out, pa_oe, irq_a, irq_b, src_a, src_b, fa, fb;
	logic [2:0]  m3;
	logic [2:0]  cm [4] = '{3'b010, 3'b110, 3'b011, 3'b111};
	wire         pa_wire;
	int          failures, n_tests, k, c, n;
	// pin A wire: the timer wins while it drives
	assign pa_wire = pa_oe ? pa_out : src_a;
	tec_timer i_tec_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_pin_a_in(pa_wire), .timer_pin_a_out(pa_out),
		.timer_pin_a_oe(pa_oe), .timer_pin_b_in(src_b), .irq_a(irq_a), .irq_b(irq_b));
	tec_pins i_tec_pins (.pclk(pclk), .pin_a(src_a), .pin_b(src_b));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] ctl(input logic [2:0] m, input logic r, pa, ea, pb, eb);
		return {24'h0, m, r, pa, ea, pb, eb};
	endfunction
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// request held until pready is seen high; read data taken at that edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && t < 16) begin
			@(posedge pclk);
			t++;
		end
		if (t == 16) begin
			failures++;
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic chk(input string nm, input logic [31:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		lf = 32'h89D0_7384;
		failures = 0;
		n_tests = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 4; k++) chk("reset", 32'(k * 4), 32'h0);
		lf = nx(lf);
		apb(1'b0, 32'h10 + {22'h0, lf[9:2], 2'b00}, 32'h0);
		`CHK("unmapped", 33'h1_0000_0000, {er, rd})
		for (k = 0; k < 2; k++) begin
			wr(TEC_OFF_CTRL, ctl(3'(k), 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
			wr(TEC_OFF_CNT, 32'h10);
			i_tec_pins.set_a(1'b1);
			chk("evt_rise", TEC_OFF_CNT, (k == 0) ? 32'hF : 32'h10);
			i_tec_pins.set_a(1'b0);
			chk("evt_fall", TEC_OFF_CNT, 32'hF);
		end
		for (k = 0; k < 3; k++) begin
			lf = nx(lf);
			c = int'(lf[1:0]);
			n = 1 + int'(lf[3:2]) + int'(lf[4]);
			// upper bits are random and must be ignored
			wr(TEC_OFF_CTRL, ctl(3'b000, 1'b1, 1'b0, lf[5], 1'b0, 1'b1) | {lf[31:8], 8'h00});
			wr(TEC_OFF_CNT, {lf[31:16], 16'(c)});
			repeat (n) begin
				i_tec_pins.set_a(1'b1);
				i_tec_pins.set_a(1'b0);
			end
			i_tec_pins.set_b(1'b1);
			i_tec_pins.set_b(1'b0);
			chk("evt_cnt", TEC_OFF_CNT, 32'((c - n) & 32'hFFFF));
			chk("evt_flags", TEC_OFF_CTRL, ctl(3'b000, 1'b1, n > c, lf[5], 1'b1, 1'b1));
			`CHK("irq_a", lf[5] & (n > c), irq_a)
			`CHK("irq_b", 1'b1, irq_b)
			`CHK("oe_evt", 1'b0, pa_oe)
		end
		wr(TEC_OFF_CTRL, 32'h0);
		wr(TEC_OFF_CNT, 32'h5);
		i_tec_pins.set_a(1'b1);
		i_tec_pins.set_a(1'b0);
		chk("stopped", TEC_OFF_CNT, 32'h5);
		wr(TEC_OFF_CNT, 32'h8000);
		for (k = 0; k < 4; k++) begin
			m3 = cm[k];
			fa = m3[0];
			fb = (m3 != 3'b010);
			wr(TEC_OFF_CTRL, ctl(m3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1));
			i_tec_pins.set_a(1'b1);
			i_tec_pins.set_b(1'b1);
			chk("cap_rise", TEC_OFF_CTRL, ctl(m3, 1'b0, !fa, 1'b1, !fb, 1'b1));
			i_tec_pins.set_a(1'b0);
			i_tec_pins.set_b(1'b0);
			chk("cap_fall", TEC_OFF_CTRL, ctl(m3, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
			apb(1'b0, TEC_OFF_RA, 32'h0);
			ra = rd;
			apb(1'b0, TEC_OFF_RB, 32'h0);
			`CHK("cap_ab", 1'b1, (ra[15:0] - rd[15:0]) < 16'h0010)
			apb(1'b0, TEC_OFF_CNT, 32'h0);
			`CHK("cap_a", 1'b1, (ra[15:0] - rd[15:0]) < 16'h0080)
			chk("cap_keep", TEC_OFF_RA, ra);
		end
		// four tc ticks of four cycles each reach underflow well inside the wait
		wr(TEC_OFF_CNT, 32'h3);
		repeat (40) @(posedge pclk);
		chk("cap_unf", TEC_OFF_CTRL, ctl(3'b111, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
		`CHK("irq_cap", 1'b1, irq_a)
		apb(1'b0, TEC_OFF_CNT, 32'h0);
		`CHK("cap_wrap", 1'b1, rd[15:0] > 16'hFF00)
		wr(TEC_OFF_CTRL, ctl(3'b101, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
		wr(TEC_OFF_RA, 32'h2);
		wr(TEC_OFF_RB, 32'h2);
		wr(TEC_OFF_CNT, 32'h1);
		repeat (60) @(posedge pclk);
		apb(1'b0, TEC_OFF_CTRL, 32'h0);
		`CHK("pwm_flags", 2'b11, {rd[3], rd[1]})
		`CHK("pwm_oe", 1'b1, pa_oe)
		// reloads of 2 give an underflow every 12 cycles
		fa = pa_out;
		for (k = 0; k < 20 && pa_out === fa; k++) @(posedge pclk);
		`CHK("pwm_toggle", 1'b1, pa_out !== fa)
		wr(TEC_OFF_CTRL, ctl(3'b100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
		@(posedge pclk);
		fa = pa_out;
		repeat (40) @(posedge pclk);
		`CHK("pwm_hold", {1'b1, fa}, {pa_oe, pa_out})
		lf = nx(lf);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3 + int'(lf[1:0])) @(posedge pclk);
		presetn <= 1'b1;
		`CHK("rst_pin", 2'b00, {pa_oe, pa_out})
		for (k = 0; k < 4; k++) chk("rerst", 32'(k * 4), 32'h0);
		`CHK("rst_irq", 2'b00, {irq_a, irq_b})
		give_verdict();
	end
endmodule // tec_timer_bench
